// ===== ext_bus_pkg.sv
`default_nettype none
package ext_bus_pkg;
	// Widths of the external port and of the register port
	localparam int DATA_W = 24;
	localparam int ATTR_N = 4;
	localparam int WS_W = 4;
	localparam int REG_AW = 3;
	localparam int REG_DW = 8;
	localparam int PHASE_W = 8;
	localparam int CLK_DIV_DEF = 4;

	// Register offsets
	localparam logic [REG_AW-1:0] REG_BUS_CTRL = 3'h0;
	localparam logic [REG_AW-1:0] REG_OP_MODE = 3'h1;
	localparam logic [REG_AW-1:0] REG_DRAM_CTRL = 3'h2;
	localparam logic [REG_AW-1:0] REG_ATTR_CFG = 3'h3;
	localparam logic [REG_AW-1:0] REG_STATUS = 3'h4;

	// Field positions
	localparam int BCR_WS_LSB = 0;
	localparam int BCR_HOLD_BIT = 4;
	localparam int OMR_SYNC_BIT = 0;
	localparam int OMR_BCLK_BIT = 1;
	localparam int DCR_BME_BIT = 0;
	localparam int ACFG_MODE_LSB = 0;
	localparam int ACFG_POL_LSB = 4;
	localparam int STAT_OWNER_BIT = 0;
	localparam int STAT_ACTIVE_BIT = 1;
	localparam int STAT_REQ_BIT = 2;

	// Reset values
	localparam logic [REG_DW-1:0] BCR_RST = 8'h01;
	localparam logic [REG_DW-1:0] OMR_RST = 8'h01;
	localparam logic [REG_DW-1:0] DCR_RST = 8'h00;
	localparam logic [REG_DW-1:0] ACFG_RST = 8'h00;

	// Arbitration and cycle states
	typedef enum logic [2:0] {
		ST_SLAVE,
		ST_OWNER,
		ST_ACCESS,
		ST_COMPLETE,
		ST_RELEASE
	} bus_state_e;
endpackage
`default_nettype wire

// ===== sync2.sv
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;

	// Two stages; only the second stage is visible outside
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== external_memory_bus_port.sv
`default_nettype none
module external_memory_bus_port
	import ext_bus_pkg::*;
#(
	parameter int CLK_DIV = CLK_DIV_DEF
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [REG_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [REG_DW-1:0] reg_rdata,
	input wire logic acc_start,
	input wire logic acc_write,
	input wire logic acc_dram,
	input wire logic [ATTR_N-1:0] acc_attr,
	input wire logic [DATA_W-1:0] acc_wdata,
	output logic acc_busy,
	output logic acc_done,
	output logic [DATA_W-1:0] acc_rdata,
	input wire logic [DATA_W-1:0] data_lines_in,
	output logic [DATA_W-1:0] data_lines_out,
	output logic data_lines_oe,
	output logic [ATTR_N-1:0] address_attribute_lines,
	output logic attr_oe,
	output logic read_n,
	output logic write_n,
	output logic strobe_oe,
	input wire logic transfer_ack_n,
	output logic bus_request_n,
	input wire logic bus_grant_n,
	input wire logic bus_busy_n_in,
	output logic bus_busy_n_out,
	output logic bus_busy_n_oe,
	output logic column_strobe_n,
	output logic column_strobe_oe,
	output logic core_clock_out,
	output logic bus_clk,
	output logic bus_clk_n,
	output logic bus_clk_oe
);
	// Divider split points; CLK_DIV must be a multiple of four
	localparam int HALF = CLK_DIV / 2;
	localparam int QTR = CLK_DIV / 4;
	localparam int SYNC_W = DATA_W + 3;

	typedef struct packed {
		// Arbitration and cycle sequencing
		bus_state_e st;
		logic [PHASE_W-1:0] phase;

		// Software-visible registers and read answer
		logic [REG_DW-1:0] bus_control_reg;
		logic [REG_DW-1:0] operating_mode_reg;
		logic [REG_DW-1:0] dram_ctrl;
		logic [REG_DW-1:0] attr_cfg;
		logic [REG_DW-1:0] rdata;

		// Access held from its start until completion
		logic pend;
		logic we;
		logic dram;
		logic [ATTR_N-1:0] attr;
		logic [DATA_W-1:0] wdata;

		// Wait counting, acknowledge history and results
		logic [WS_W-1:0] ws_cnt;
		logic ack_prev;
		logic done;
		logic [DATA_W-1:0] rd_word;

		// Registered images of every pin
		logic clk_out;
		logic bclk;
		logic bclk_oe;
		logic [DATA_W-1:0] dout;
		logic dout_oe;
		logic [ATTR_N-1:0] attr_out;
		logic attr_oe;
		logic rd_n;
		logic wr_n;
		logic strobe_oe;
		logic req_n;
		logic busy_out;
		logic busy_oe;
		logic cas_n;
		logic cas_oe;
	} port_state_s;

	port_state_s s_r;
	port_state_s s_nxt;
	// Resynchronised pin images
	logic [SYNC_W-1:0] pins_s;
	logic [DATA_W-1:0] data_s;
	logic ack_n_s;
	logic grant_n_s;
	logic busy_n_s;

	// Every pin input is resynchronised before use
	sync2 #(
		.WIDTH(SYNC_W)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst(rst),
		.din({data_lines_in, transfer_ack_n, bus_grant_n, bus_busy_n_in}),
		.dout(pins_s)
	);

	// Data word is only captured long after it has settled
	assign data_s = pins_s[SYNC_W-1:3];
	assign ack_n_s = pins_s[2];
	assign grant_n_s = pins_s[1];
	assign busy_n_s = pins_s[0];

	// Next-state logic for registers, arbitration, cycles and pins
	always_comb begin
		logic tick;
		logic want;
		logic ack_ok;
		logic owner;
		logic [WS_W-1:0] ws_min;
		int ph_lead;
		tick = 1'b0;
		want = 1'b0;
		ack_ok = 1'b0;
		owner = 1'b0;
		ws_min = '0;
		ph_lead = 0;
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.rdata = '0;

		// Output clock divider; one tick per output clock period
		tick = (s_r.phase == PHASE_W'(CLK_DIV - 1));
		s_nxt.phase = tick ? '0 : s_r.phase + 1'b1;

		// Register writes; reads answer in the next cycle
		if (reg_wr) begin
			unique case (reg_addr)
				REG_BUS_CTRL: s_nxt.bus_control_reg = reg_wdata;
				REG_OP_MODE: s_nxt.operating_mode_reg = reg_wdata;
				REG_DRAM_CTRL: s_nxt.dram_ctrl = reg_wdata;
				REG_ATTR_CFG: s_nxt.attr_cfg = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				REG_BUS_CTRL: s_nxt.rdata = s_r.bus_control_reg;
				REG_OP_MODE: s_nxt.rdata = s_r.operating_mode_reg;
				REG_DRAM_CTRL: s_nxt.rdata = s_r.dram_ctrl;
				REG_ATTR_CFG: s_nxt.rdata = s_r.attr_cfg;
				REG_STATUS: begin
					s_nxt.rdata[STAT_OWNER_BIT] = (s_r.st != ST_SLAVE) &&
						(s_r.st != ST_RELEASE);
					s_nxt.rdata[STAT_ACTIVE_BIT] = s_r.pend;
					s_nxt.rdata[STAT_REQ_BIT] = ~s_r.req_n;
				end
				default: s_nxt.rdata = '0;
			endcase
		end

		// Access requests from the core side; a start while busy is dropped
		if (acc_start && !s_r.pend) begin
			s_nxt.pend = 1'b1;
			s_nxt.we = acc_write;
			s_nxt.dram = acc_dram;
			s_nxt.attr = acc_attr;
			s_nxt.wdata = acc_wdata;
		end

		// Programmed minimum wait count
		ws_min = s_r.bus_control_reg[BCR_WS_LSB +: WS_W];
		// Async mode needs two agreeing samples, trading one output clock period of latency
		if (s_r.operating_mode_reg[OMR_SYNC_BIT]) begin
			ack_ok = !ack_n_s;
		end else begin
			ack_ok = !ack_n_s && s_r.ack_prev;
		end

		// Arbitration and cycle sequencing, advanced on output clock ticks
		if (tick) begin
			unique case (s_r.st)
				// Wait for grant and a free bus before owning
				ST_SLAVE: begin
					if (!s_r.req_n && !grant_n_s && busy_n_s) begin
						s_nxt.st = ST_OWNER;
					end
				end
				// Owner parks here between cycles while grant holds
				ST_OWNER: begin
					if (grant_n_s) begin
						s_nxt.st = ST_RELEASE;
					end else if (s_r.pend) begin
						s_nxt.st = ST_ACCESS;
						s_nxt.ws_cnt = '0;
						s_nxt.ack_prev = 1'b0;
					end
				end
				// Strobes active; minimum waits first, then acknowledge unless the wait count is zero or the cycle is DRAM
				ST_ACCESS: begin
					// Acknowledge is only looked at here
					s_nxt.ack_prev = !ack_n_s;
					if (s_r.ws_cnt < ws_min) begin
						s_nxt.ws_cnt = s_r.ws_cnt + 1'b1;
					end else if (ws_min == '0 || s_r.dram || ack_ok) begin
						s_nxt.st = ST_COMPLETE;
					end
					// Otherwise stay: acknowledge still deasserted
				end
				// Final period; read word is taken at its end
				ST_COMPLETE: begin
					s_nxt.st = ST_OWNER;
					s_nxt.pend = 1'b0;
					s_nxt.done = 1'b1;
					if (!s_r.we) begin
						s_nxt.rd_word = data_s;
					end
				end
				// One period of busy driven high before letting go
				ST_RELEASE: s_nxt.st = ST_SLAVE;
			endcase
		end

		// Request tracks need, independent of ownership
		want = s_nxt.pend || s_r.bus_control_reg[BCR_HOLD_BIT];
		s_nxt.req_n = !want;

		// Owner covers every state in which this side holds the bus
		owner = (s_nxt.st == ST_OWNER) || (s_nxt.st == ST_ACCESS) || (s_nxt.st == ST_COMPLETE);

		// Busy: low while owning, high for one period on release, then let go
		s_nxt.busy_oe = owner || (s_nxt.st == ST_RELEASE);
		s_nxt.busy_out = !owner;

		// Strobes and data are only driven by the owner
		s_nxt.strobe_oe = owner;
		s_nxt.rd_n = !((s_nxt.st == ST_ACCESS || s_nxt.st == ST_COMPLETE) && !s_nxt.we);
		s_nxt.wr_n = !((s_nxt.st == ST_ACCESS || s_nxt.st == ST_COMPLETE) && s_nxt.we);
		s_nxt.dout_oe = owner && s_nxt.pend && s_nxt.we;
		s_nxt.dout = s_nxt.wdata;

		// Attribute lines: select per line, row strobes follow polarity bit
		s_nxt.attr_oe = owner;
		for (int i = 0; i < ATTR_N; i++) begin
			if (s_r.attr_cfg[ACFG_MODE_LSB + i]) begin
				s_nxt.attr_out[i] = s_r.attr_cfg[ACFG_POL_LSB + i] ~^
					((s_nxt.st == ST_ACCESS || s_nxt.st == ST_COMPLETE) &&
					s_nxt.dram && s_nxt.attr[i]);
			end else begin
				s_nxt.attr_out[i] = s_nxt.pend && s_nxt.attr[i];
			end
		end

		// Column strobe in the final period of a DRAM cycle
		s_nxt.cas_oe = owner || s_r.dram_ctrl[DCR_BME_BIT];
		s_nxt.cas_n = !(owner && s_nxt.st == ST_COMPLETE && s_nxt.dram);

		// Output clock and bus clock pair, bus clock leading by a quarter
		s_nxt.clk_out = (int'(s_nxt.phase) < HALF);
		ph_lead = (int'(s_nxt.phase) + QTR) % CLK_DIV;
		s_nxt.bclk = (ph_lead < HALF);
		s_nxt.bclk_oe = owner && s_r.operating_mode_reg[OMR_BCLK_BIT];
	end

	// Single state register; reset puts arbitration in slave state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// Strobes and busy idle high so nothing pulses low out of reset
			s_r <= '0;
			s_r.st <= ST_SLAVE;
			s_r.req_n <= 1'b1;
			s_r.bus_control_reg <= BCR_RST;
			s_r.operating_mode_reg <= OMR_RST;
			s_r.dram_ctrl <= DCR_RST;
			s_r.attr_cfg <= ACFG_RST;
			s_r.rd_n <= 1'b1;
			s_r.wr_n <= 1'b1;
			s_r.busy_out <= 1'b1;
			s_r.cas_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Ports come straight from the state register
	assign reg_rdata = s_r.rdata;
	assign acc_busy = s_r.pend;
	assign acc_done = s_r.done;
	assign acc_rdata = s_r.rd_word;

	// Data and attribute pins
	assign data_lines_out = s_r.dout;
	assign data_lines_oe = s_r.dout_oe;
	assign address_attribute_lines = s_r.attr_out;
	assign attr_oe = s_r.attr_oe;

	// Strobes and arbitration pins
	assign read_n = s_r.rd_n;
	assign write_n = s_r.wr_n;
	assign strobe_oe = s_r.strobe_oe;
	assign bus_request_n = s_r.req_n;
	assign bus_busy_n_out = s_r.busy_out;
	assign bus_busy_n_oe = s_r.busy_oe;
	assign column_strobe_n = s_r.cas_n;
	assign column_strobe_oe = s_r.cas_oe;

	// Clock pins
	assign core_clock_out = s_r.clk_out;
	assign bus_clk = s_r.bclk;
	assign bus_clk_n = ~s_r.bclk; // Inverse comes from the same flop
	assign bus_clk_oe = s_r.bclk_oe;
endmodule
`default_nettype wire

// ===== ext_bus_asserts.sv
`default_nettype none
module ext_bus_asserts
	import ext_bus_pkg::*;
#(
	parameter int CLK_DIV = CLK_DIV_DEF
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic acc_start,
	input wire logic acc_busy,
	input wire logic acc_done,
	input wire logic data_lines_oe,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic strobe_oe,
	input wire logic bus_request_n,
	input wire logic bus_grant_n,
	input wire logic bus_busy_n_in,
	input wire logic bus_busy_n_out,
	input wire logic bus_busy_n_oe,
	input wire logic column_strobe_n,
	input wire logic column_strobe_oe,
	input wire logic bus_clk,
	input wire logic bus_clk_n,
	input wire logic bus_clk_oe
);
	// One domain, so clock and reset are given once
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_data_owner: assert property (data_lines_oe |-> bus_busy_n_oe)
		else $error("data bus driven without ownership");
	chk_rd_owner: assert property (!read_n |-> strobe_oe && bus_busy_n_oe)
		else $error("read strobe active without ownership");
	chk_wr_owner: assert property (!write_n |-> strobe_oe && bus_busy_n_oe)
		else $error("write strobe active without ownership");
	chk_done_pending: assert property (acc_done |-> $past(acc_busy))
		else $error("cycle ended with nothing pending");
	chk_req_start: assert property (acc_start && !acc_busy |-> ##[1:2] !bus_request_n)
		else $error("request missing after access start");
	chk_req_reset: assert property ($fell(rst) |-> bus_request_n)
		else $error("request asserted out of reset");
	// Busy taken only from an idle pin with grant present
	chk_take_busy: assert property ($rose(bus_busy_n_oe) |->
		$past(bus_busy_n_in, 3) && !$past(bus_grant_n, 3)) else $error("busy taken while busy");
	chk_busy_release: assert property ($fell(bus_busy_n_oe) |-> $past(bus_busy_n_out))
		else $error("busy released without driving high");
	chk_cas_owner: assert property (!column_strobe_n |-> column_strobe_oe && bus_busy_n_oe)
		else $error("column strobe active without ownership");
	chk_bclk_pair: assert property (bus_clk_oe |-> bus_busy_n_oe && bus_clk_n != bus_clk)
		else $error("bus clock pair wrong");
endmodule
bind external_memory_bus_port ext_bus_asserts #(.CLK_DIV(CLK_DIV)) u_chk (.core_clk(core_clk),
	.rst(rst), .acc_start(acc_start), .acc_busy(acc_busy), .acc_done(acc_done),
	.data_lines_oe(data_lines_oe), .read_n(read_n), .write_n(write_n), .strobe_oe(strobe_oe),
	.bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n), .bus_busy_n_in(bus_busy_n_in),
	.bus_busy_n_out(bus_busy_n_out), .bus_busy_n_oe(bus_busy_n_oe),
	.column_strobe_n(column_strobe_n), .column_strobe_oe(column_strobe_oe),
	.bus_clk(bus_clk), .bus_clk_n(bus_clk_n), .bus_clk_oe(bus_clk_oe));
`default_nettype wire

// ===== ext_bus_partner.sv
`default_nettype none
module ext_bus_partner
	import ext_bus_pkg::*;
(
	input wire logic core_clk,
	input wire logic core_clock_out,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic strobe_oe,
	input wire logic [DATA_W-1:0] data_lines_out,
	input wire logic data_lines_oe,
	input wire logic bus_busy_n_out,
	input wire logic bus_busy_n_oe,
	input wire logic grant_req,
	input wire logic other_busy,
	input wire logic [7:0] ack_wait,
	output logic [DATA_W-1:0] data_lines_in,
	output logic transfer_ack_n,
	output logic bus_grant_n,
	output logic bus_busy_n_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem;
	logic prev_co;
	logic strobe;
	int cnt;
	initial begin
		mem = 24'h000000;
		prev_co = 1'b0;
		cnt = 0;
		data_lines_in = 24'h000000;
		transfer_ack_n = 1'b1;
		bus_grant_n = 1'b1;
	end
	// Pull-up holds busy high once nobody drives it
	assign bus_busy_n_in = bus_busy_n_oe ? bus_busy_n_out : !other_busy;
	assign strobe = strobe_oe && !(read_n && write_n);
	// Memory, slow or prompt acknowledge, and grant
	always @(posedge core_clk) begin
		prev_co <= core_clock_out;
		if (core_clock_out && !prev_co) bus_grant_n <= !grant_req;
		cnt <= strobe ? cnt + 1 : 0;
		transfer_ack_n <= !(strobe && cnt >= int'(ack_wait));
		if (strobe && !write_n && data_lines_oe) mem <= data_lines_out;
		// Released bus keeps changing so stale data cannot pass
		data_lines_in <= (strobe_oe && !read_n) ? mem : ~data_lines_in;
	end
endmodule
`default_nettype wire

// ===== tb_external_memory_bus_port.sv
`default_nettype none
module tb_external_memory_bus_port
	import ext_bus_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CD = 4;
	logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, acc_start = 0, acc_write = 0;
	logic acc_dram = 0, grant_req = 0, other_busy = 0, cas_seen = 0, bclk_seen = 0;
	logic [2:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, ack_wait = 0, reg_rdata;
	logic [3:0] acc_attr = 0, aal;
	logic [23:0] acc_wdata = 0, acc_rdata, dli, dlo, mem_m;
	logic acc_busy, acc_done, dloe, attr_oe, read_n, write_n, strobe_oe, ta_n, br_n, bg_n;
	logic bbi, bbo, bboe, cas_n, cas_oe, cko, bclk, bclk_n, bclk_oe;
	logic [31:0] seed = 32'h7784, r;
	logic [7:0] acfg_m = 0;
	int errors = 0, cmp_count = 0, c, lo, k, ph_m = -1;
	external_memory_bus_port #(.CLK_DIV(CD)) DUT (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .acc_start(acc_start), .acc_write(acc_write),
		.acc_dram(acc_dram), .acc_attr(acc_attr), .acc_wdata(acc_wdata), .acc_busy(acc_busy),
		.acc_done(acc_done), .acc_rdata(acc_rdata), .data_lines_in(dli), .data_lines_out(dlo),
		.data_lines_oe(dloe), .address_attribute_lines(aal), .attr_oe(attr_oe),
		.read_n(read_n), .write_n(write_n), .strobe_oe(strobe_oe), .transfer_ack_n(ta_n),
		.bus_request_n(br_n), .bus_grant_n(bg_n), .bus_busy_n_in(bbi), .bus_busy_n_out(bbo),
		.bus_busy_n_oe(bboe), .column_strobe_n(cas_n), .column_strobe_oe(cas_oe),
		.core_clock_out(cko), .bus_clk(bclk), .bus_clk_n(bclk_n), .bus_clk_oe(bclk_oe));
	ext_bus_partner u_far (.core_clk(core_clk), .core_clock_out(cko), .read_n(read_n),
		.write_n(write_n), .strobe_oe(strobe_oe), .data_lines_out(dlo), .data_lines_oe(dloe),
		.bus_busy_n_out(bbo), .bus_busy_n_oe(bboe), .grant_req(grant_req),
		.other_busy(other_busy), .ack_wait(ack_wait), .data_lines_in(dli),
		.transfer_ack_n(ta_n), .bus_grant_n(bg_n), .bus_busy_n_in(bbi));
	always #5 core_clk = ~core_clk;
	// Sticky monitors for pins that only move mid-cycle
	always @(posedge core_clk) begin
		if (!cas_n && cas_oe) cas_seen <= 1;
		if (bclk_oe) bclk_seen <= 1;
	end
	// Output clock and bus clock pair against a phase count
	always begin
		@(posedge core_clk);
		#1;
		if (rst) ph_m = -1;
		else begin
			ph_m++;
			if (ph_m > 0) check(cko, (ph_m % CD) < CD / 2);
			if (bclk_oe) check(bclk, ((ph_m + CD / 4) % CD) < CD / 2);
			if (bclk_oe) check(bclk_n, !bclk);
		end
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test();
		if (errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 check(reg_rdata, e);
	endtask
	// One access; the model keeps the last word written
	task acc(input logic w, input logic dr, input logic [23:0] d);
		logic [3:0] a;
		a = seed[3:0];
		@(posedge core_clk);
		acc_write <= w;
		acc_dram <= dr;
		acc_wdata <= d;
		acc_attr <= a;
		acc_start <= 1;
		@(posedge core_clk);
		acc_start <= 0;
		#1 check(aal, a & ~acfg_m[3:0]);
		check(acc_busy, 1);
		for (c = 0; c < 3000; c++) begin
			@(posedge core_clk);
			#1;
			if (acc_done === 1'b1) break;
		end
		if (c == 3000) begin
			errors++;
			finish_test();
		end
		if (w) mem_m = d;
		else check(acc_rdata, mem_m);
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 0;
		#1 check(br_n, 1);
		check(strobe_oe, 0);
		rd(REG_BUS_CTRL, 8'h01);
		rd(REG_OP_MODE, 8'h01);
		rd(REG_ATTR_CFG, 8'h00);
		wr(3'h6, 8'hFF);
		rd(3'h6, 8'h00);
		grant_req <= 1;
		// Programmed minimum against a prompt, then a slow acknowledge
		for (k = 0; k < 4; k++) begin
			wr(REG_BUS_CTRL, (k % 2) ? 8'h06 : 8'h01);
			ack_wait <= (k > 1) ? 8'd60 : 8'd0;
			r = rnd();
			acc(1, 0, r[23:0]);
			acc(0, 0, 24'h000000);
			lo = (k % 2) ? 6 * CD : CD;
			if (k > 1 && lo < 60) lo = 60;
			check(c >= lo && c < lo + 16 * CD, 1);
		end
		rd(REG_STATUS, 8'h01);
		wr(REG_OP_MODE, 8'h02);
		ack_wait <= 8'd20;
		acc(0, 0, 24'h000000);
		check(bclk_seen, 1);
		// Zero waits on DRAM: acknowledge is never given
		wr(REG_BUS_CTRL, 8'h00);
		wr(REG_DRAM_CTRL, 8'h01);
		wr(REG_ATTR_CFG, 8'hFF);
		acfg_m = 8'hFF;
		ack_wait <= 8'd250;
		r = rnd();
		acc(1, 1, r[23:0]);
		acc(0, 1, 24'h000000);
		check(cas_seen, 1);
		wr(REG_BUS_CTRL, 8'h11);
		repeat (3) @(posedge core_clk);
		#1 check(br_n, 0);
		wr(REG_BUS_CTRL, 8'h01);
		repeat (3) @(posedge core_clk);
		#1 check(br_n, 1);
		grant_req <= 0;
		for (k = 0; k < 60 && bboe !== 1'b0; k++) @(posedge core_clk);
		#1 check(bboe, 0);
		check(dloe, 0);
		check(bclk_oe, 0);
		check(cas_n, 1);
		check(cas_oe, 1);
		check(attr_oe, 0);
		// Another master holds busy while grant arrives
		other_busy <= 1;
		grant_req <= 1;
		ack_wait <= 8'd0;
		fork
			acc(1, 0, 24'hA5C3F0);
			begin
				repeat (40) @(posedge core_clk);
				check(bboe, 0);
				other_busy <= 0;
			end
		join
		acc(0, 0, 24'h000000);
		finish_test();
	end
endmodule
`default_nettype wire
